//--- design/dopm_defines.svh
`ifndef DOPM_DEFINES_SVH
`define DOPM_DEFINES_SVH

// Register addresses on the special-function-register bus
`define DOPM_ADDR_CTRL        8'hAE
`define DOPM_ADDR_DUTY_A_LO   8'hB1
`define DOPM_ADDR_DUTY_A_HI   8'hB2
`define DOPM_ADDR_DUTY_B_LO   8'hB3
`define DOPM_ADDR_DUTY_B_HI   8'hB4

// Control register fields and reset value
`define DOPM_CTRL_RESET       7'h00
`define DOPM_MODE_MSB         6
`define DOPM_MODE_LSB         4
`define DOPM_PRESC_MSB        3
`define DOPM_PRESC_LSB        2
`define DOPM_SRC_MSB          1
`define DOPM_SRC_LSB          0

// Clock source codes
`define DOPM_SRC_XTAL_DIV     2'h0
`define DOPM_SRC_XTAL         2'h1
`define DOPM_SRC_EXT_PIN      2'h2
`define DOPM_SRC_PLL          2'h3

// Crystal divider and prescaler masks
`define DOPM_XTAL_DIV_LAST    4'hE
`define DOPM_PRESC_MASK_1     6'h00
`define DOPM_PRESC_MASK_4     6'h03
`define DOPM_PRESC_MASK_16    6'h0F
`define DOPM_PRESC_MASK_64    6'h3F

// Data register reset value and full counter range end
`define DOPM_DATA_RESET       8'h00
`define DOPM_CNT_LAST         16'hFFFF

`endif

//--- design/dopm_pkg.sv
package dopm_pkg;

  // Operating modes in mode-field order
  typedef enum logic [2:0] {
    DOPM_MODE_OFF,
    DOPM_MODE_SINGLE16,
    DOPM_MODE_TWIN8,
    DOPM_MODE_TWIN16,
    DOPM_MODE_SD_NRZ,
    DOPM_MODE_DUAL8,
    DOPM_MODE_SD_RZ,
    DOPM_MODE_HOLD
  } dopm_mode_e;

  typedef logic [15:0] dopm_word_t;

endpackage

//--- design/dopm_sd_if.sv
`timescale 1ns/10ps

// Links the top to one pulse-density channel
interface dopm_sd_if;
  logic               step;
  logic               clear;
  dopm_pkg::dopm_word_t value;
  logic               bit_out;

  modport ctrl (output step, output clear, output value, input bit_out);
  modport chan (input step, input clear, input value, output bit_out);
endinterface

//--- design/dopm_sd_chan.sv
`timescale 1ns/10ps
`include "dopm_defines.svh"

module dopm_sd_chan (
  input  wire logic ref_clk,
  input  wire logic rst,
  dopm_sd_if.chan   sd
);

  logic [15:0] acc_ff;
  logic        bit_ff;
  logic [16:0] sum;

  // First-order accumulator: carry out is the density bit
  assign sum = {1'b0, acc_ff} + {1'b0, sd.value};
  assign sd.bit_out = bit_ff;

  // even spread: carries over 65536 steps equal the value
  always_ff @(posedge ref_clk) begin
    if (rst || sd.clear) begin
      acc_ff <= 16'h0000;
      bit_ff <= 1'b0;
    end else if (sd.step) begin
      acc_ff <= sum[15:0];
      bit_ff <= sum[16];
    end
  end

endmodule

//--- design/dopm_top.sv
`timescale 1ns/10ps
`include "dopm_defines.svh"

module dopm_top (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       crystal_clk_in,
  input  wire logic       pll_clk_in,
  input  wire logic       external_clock_pin,
  output logic            output_pin_a,
  output logic            output_pin_b,
  output logic            pin_a_oe_n,
  output logic            pin_b_oe_n
);

  logic [6:0]  ctrl_ff;
  logic [7:0]  hold_a_ff, hold_b_ff;
  logic [15:0] vis_a_ff, vis_b_ff;
  logic [15:0] act_a_ff, act_b_ff;
  logic [15:0] cnt_ff;
  logic [2:0]  xs_ff, ps_ff, es_ff;
  logic [3:0]  xdiv_ff;
  logic [5:0]  pre_ff;
  logic [15:0] since_ff, span_ff;
  logic [7:0]  rdata_ff;
  logic        out_a_ff, out_b_ff, oe_n_a_ff, oe_n_b_ff;

  dopm_pkg::dopm_mode_e mode;
  logic        wr_ctrl, wr_a_lo, wr_a_hi, wr_b_lo, wr_b_hi, is16;
  logic        x_edge, p_edge, e_edge, xdiv_tick, src_tick, tick;
  logic [5:0]  pmask;
  logic        wrap_lo, wrap_hi, wrap16, boundary, rz_low, hold;
  logic [15:0] nxt_cnt;
  logic        nxt_a, nxt_b, pins_used;

  dopm_sd_if sd_a ();
  dopm_sd_if sd_b ();

  assign mode    = dopm_pkg::dopm_mode_e'(ctrl_ff[`DOPM_MODE_MSB:`DOPM_MODE_LSB]);
  assign is16    = (mode == dopm_pkg::DOPM_MODE_SINGLE16) || (mode == dopm_pkg::DOPM_MODE_TWIN16)
                || (mode == dopm_pkg::DOPM_MODE_SD_NRZ) || (mode == dopm_pkg::DOPM_MODE_SD_RZ);
  assign hold    = (mode == dopm_pkg::DOPM_MODE_OFF) || (mode == dopm_pkg::DOPM_MODE_HOLD);

  // Write strobes by address
  assign wr_ctrl = sfr_wr && (sfr_addr == `DOPM_ADDR_CTRL);
  assign wr_a_lo = sfr_wr && (sfr_addr == `DOPM_ADDR_DUTY_A_LO);
  assign wr_a_hi = sfr_wr && (sfr_addr == `DOPM_ADDR_DUTY_A_HI);
  assign wr_b_lo = sfr_wr && (sfr_addr == `DOPM_ADDR_DUTY_B_LO);
  assign wr_b_hi = sfr_wr && (sfr_addr == `DOPM_ADDR_DUTY_B_HI);

  // control register, bit 7 not kept
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff <= `DOPM_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= sfr_wdata[6:0];
    end
  end

  // low bytes park in the hidden holder in 16-bit modes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_a_ff <= `DOPM_DATA_RESET;
      hold_b_ff <= `DOPM_DATA_RESET;
    end else begin
      if (wr_a_lo) hold_a_ff <= sfr_wdata;
      if (wr_b_lo) hold_b_ff <= sfr_wdata;
    end
  end

  // high byte write moves both bytes into the visible pair in 16-bit modes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vis_a_ff <= {`DOPM_DATA_RESET, `DOPM_DATA_RESET};
      vis_b_ff <= {`DOPM_DATA_RESET, `DOPM_DATA_RESET};
    end else begin
      if (wr_a_hi) vis_a_ff <= {sfr_wdata, is16 ? hold_a_ff : vis_a_ff[7:0]};
      else if (wr_a_lo && !is16) vis_a_ff[7:0] <= sfr_wdata;
      if (wr_b_hi) vis_b_ff <= {sfr_wdata, is16 ? hold_b_ff : vis_b_ff[7:0]};
      else if (wr_b_lo && !is16) vis_b_ff[7:0] <= sfr_wdata;
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      case (sfr_addr)
        `DOPM_ADDR_CTRL:      rdata_ff <= {1'b0, ctrl_ff};
        `DOPM_ADDR_DUTY_A_LO: rdata_ff <= vis_a_ff[7:0];
        `DOPM_ADDR_DUTY_A_HI: rdata_ff <= vis_a_ff[15:8];
        `DOPM_ADDR_DUTY_B_LO: rdata_ff <= vis_b_ff[7:0];
        `DOPM_ADDR_DUTY_B_HI: rdata_ff <= vis_b_ff[15:8];
        default:              rdata_ff <= 8'h00;
      endcase
    end
  end
  assign sfr_rdata = rdata_ff;

  // two-stage synchronisers plus an edge stage for the clock pins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xs_ff <= 3'h0;
      ps_ff <= 3'h0;
      es_ff <= 3'h0;
    end else begin
      xs_ff <= {xs_ff[1:0], crystal_clk_in};
      ps_ff <= {ps_ff[1:0], pll_clk_in};
      es_ff <= {es_ff[1:0], external_clock_pin};
    end
  end
  assign x_edge = xs_ff[1] && !xs_ff[2];
  assign p_edge = ps_ff[1] && !ps_ff[2];
  assign e_edge = es_ff[1] && !es_ff[2];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xdiv_ff <= 4'h0;
    end else if (x_edge) begin
      xdiv_ff <= (xdiv_ff == `DOPM_XTAL_DIV_LAST) ? 4'h0 : xdiv_ff + 4'h1;
    end
  end
  assign xdiv_tick = x_edge && (xdiv_ff == `DOPM_XTAL_DIV_LAST);

  assign src_tick = (ctrl_ff[`DOPM_SRC_MSB:`DOPM_SRC_LSB] == `DOPM_SRC_XTAL_DIV) ? xdiv_tick
                  : (ctrl_ff[`DOPM_SRC_MSB:`DOPM_SRC_LSB] == `DOPM_SRC_XTAL)     ? x_edge
                  : (ctrl_ff[`DOPM_SRC_MSB:`DOPM_SRC_LSB] == `DOPM_SRC_EXT_PIN)  ? e_edge
                  : p_edge;

  // prescaler: tick when the low bits under the mask are all ones
  assign pmask = (ctrl_ff[`DOPM_PRESC_MSB:`DOPM_PRESC_LSB] == 2'h0) ? `DOPM_PRESC_MASK_1
               : (ctrl_ff[`DOPM_PRESC_MSB:`DOPM_PRESC_LSB] == 2'h1) ? `DOPM_PRESC_MASK_4
               : (ctrl_ff[`DOPM_PRESC_MSB:`DOPM_PRESC_LSB] == 2'h2) ? `DOPM_PRESC_MASK_16
               : `DOPM_PRESC_MASK_64;
  assign tick  = src_tick && ((pre_ff & pmask) == pmask);

  always_ff @(posedge ref_clk) begin
    if (rst || wr_ctrl) begin
      pre_ff <= 6'h00;
    end else if (src_tick) begin
      pre_ff <= pre_ff + 6'h01;
    end
  end

  // Period ends per mode; pair B holds the periods in modes one, two and five
  assign wrap16  = (cnt_ff == `DOPM_CNT_LAST);
  assign wrap_lo = (cnt_ff[7:0] == act_b_ff[7:0]);
  assign wrap_hi = (cnt_ff[15:8] == act_b_ff[15:8]);
  assign boundary = tick && (
      (mode == dopm_pkg::DOPM_MODE_SINGLE16) ? (cnt_ff + 16'h0001 == act_b_ff)
    : (mode == dopm_pkg::DOPM_MODE_TWIN8 || mode == dopm_pkg::DOPM_MODE_DUAL8) ? wrap_lo
    : wrap16);

  // Next count; mode five steps both bytes as separate counters
  always_comb begin
    nxt_cnt = cnt_ff + 16'h0001;
    case (mode)
      dopm_pkg::DOPM_MODE_SINGLE16: if (cnt_ff + 16'h0001 == act_b_ff) nxt_cnt = 16'h0000;
      dopm_pkg::DOPM_MODE_TWIN8:    nxt_cnt = {8'h00, wrap_lo ? 8'h00 : cnt_ff[7:0] + 8'h01};
      dopm_pkg::DOPM_MODE_DUAL8:    nxt_cnt = {wrap_hi ? 8'h00 : cnt_ff[15:8] + 8'h01,
                                               wrap_lo ? 8'h00 : cnt_ff[7:0] + 8'h01};
      default:                      nxt_cnt = cnt_ff + 16'h0001;
    endcase
  end

  // control write clears the count; hold modes keep it cleared
  always_ff @(posedge ref_clk) begin
    if (rst || wr_ctrl || hold) begin
      cnt_ff <= 16'h0000;
    end else if (tick) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // working copies take the new pair at the period end, on a control write and in the hold modes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      act_a_ff <= 16'h0000;
      act_b_ff <= 16'h0000;
    end else if (boundary || wr_ctrl || hold) begin
      act_a_ff <= vis_a_ff;
      act_b_ff <= vis_b_ff;
    end
  end

  // Interval between ticks, for the half-clock low in RZ form
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      since_ff <= 16'h0000;
      span_ff  <= 16'h0000;
    end else if (tick) begin
      since_ff <= 16'h0000;
      span_ff  <= since_ff + 16'h0001;
    end else if (since_ff != 16'hFFFF) begin
      since_ff <= since_ff + 16'h0001;
    end
  end
  // second half of each step returns low
  assign rz_low = (since_ff + 16'h0001) > {1'b0, span_ff[15:1]};

  // two density channels fed from the data pairs
  assign sd_a.step  = tick;
  assign sd_b.step  = tick;
  assign sd_a.clear = wr_ctrl || hold;
  assign sd_b.clear = wr_ctrl || hold;
  assign sd_a.value = act_a_ff;
  assign sd_b.value = act_b_ff;

  dopm_sd_chan u_sd_a (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sd      (sd_a)
  );

  dopm_sd_chan u_sd_b (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sd      (sd_b)
  );

  always_comb begin
    nxt_a = 1'b0;
    nxt_b = 1'b0;
    case (mode)
      dopm_pkg::DOPM_MODE_SINGLE16: nxt_a = cnt_ff < act_a_ff;
      // A falls on low duty byte, B windowed
      dopm_pkg::DOPM_MODE_TWIN8: begin
        nxt_a = cnt_ff[7:0] < act_a_ff[7:0];
        nxt_b = (cnt_ff[7:0] >= act_b_ff[15:8]) && (cnt_ff[7:0] < act_a_ff[15:8]);
      end
      dopm_pkg::DOPM_MODE_TWIN16: begin
        nxt_a = cnt_ff < act_a_ff;
        nxt_b = cnt_ff < act_b_ff;
      end
      dopm_pkg::DOPM_MODE_SD_NRZ: begin
        nxt_a = sd_a.bit_out;
        nxt_b = sd_b.bit_out;
      end
      // each byte counter drives its own pin
      dopm_pkg::DOPM_MODE_DUAL8: begin
        nxt_a = cnt_ff[7:0] < act_a_ff[7:0];
        nxt_b = cnt_ff[15:8] < act_a_ff[15:8];
      end
      // density bit masked in the second half
      dopm_pkg::DOPM_MODE_SD_RZ: begin
        nxt_a = sd_a.bit_out && !rz_low;
        nxt_b = sd_b.bit_out && !rz_low;
      end
      default: begin
        nxt_a = 1'b0;
        nxt_b = 1'b0;
      end
    endcase
  end

  // pins released in modes zero and seven, B unused in mode one
  assign pins_used = !hold;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_a_ff  <= 1'b0;
      out_b_ff  <= 1'b0;
      oe_n_a_ff <= 1'b1;
      oe_n_b_ff <= 1'b1;
    end else begin
      out_a_ff  <= nxt_a;
      out_b_ff  <= nxt_b;
      oe_n_a_ff <= !pins_used;
      oe_n_b_ff <= !pins_used || (mode == dopm_pkg::DOPM_MODE_SINGLE16);
    end
  end

  assign output_pin_a = out_a_ff;
  assign output_pin_b = out_b_ff;
  assign pin_a_oe_n   = oe_n_a_ff;
  assign pin_b_oe_n   = oe_n_b_ff;

endmodule

//--- sim/dopm_top_sva.sv
`timescale 1ns/10ps
`include "dopm_defines.svh"
// Port-level checks; the mode is tracked from bus writes alone
module dopm_top_sva (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       output_pin_a,
  input wire logic       output_pin_b,
  input wire logic       pin_a_oe_n,
  input wire logic       pin_b_oe_n
);
  logic [6:0] ctl_ff;
  logic [2:0] age_ff;
  logic [2:0] nxt_age;
  logic [2:0] md;
  logic       cw;
  logic       quiet;
  logic       rel_ab;

  // Age saturates so the settle test never wraps back to zero
  assign cw      = sfr_wr && sfr_addr == `DOPM_ADDR_CTRL;
  assign md      = ctl_ff[`DOPM_MODE_MSB:`DOPM_MODE_LSB];
  assign quiet   = age_ff > 3'h2;
  assign nxt_age = cw ? 3'h0 : age_ff + {2'h0, age_ff != 3'h7};
  assign rel_ab  = pin_a_oe_n && pin_b_oe_n && !output_pin_a && !output_pin_b;

  // Shadow of the control register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_ff <= `DOPM_CTRL_RESET;
      age_ff <= 3'h0;
    end else begin
      age_ff <= nxt_age;
      if (cw) begin
        ctl_ff <= sfr_wdata[6:0];
      end
    end
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_RESET_STATE: assert property (
    $past(rst) |-> rel_ab && sfr_rdata == 8'h00) else $error("bad reset state");
  AST_CTRL_READ: assert property (
    sfr_addr == `DOPM_ADDR_CTRL && !sfr_wr |=> sfr_rdata == {1'b0, $past(ctl_ff)})
    else $error("control readback");
  AST_MODE_OFF: assert property (md == 3'h0 && quiet |-> rel_ab) else $error("mode 0");
  AST_MODE_HOLD: assert property (md == 3'h7 && quiet |-> rel_ab) else $error("mode 7");
  AST_SINGLE_OUT: assert property (
    md == 3'h1 && quiet |-> !pin_a_oe_n && pin_b_oe_n) else $error("mode 1 enables");
  AST_DUAL_OUT: assert property (
    md inside {[3'h2:3'h6]} && quiet |-> !pin_a_oe_n && !pin_b_oe_n) else $error("enables");
  AST_HIGH_PAIR: assert property (
    sfr_wr && sfr_addr == `DOPM_ADDR_DUTY_A_HI ##1 sfr_addr == `DOPM_ADDR_DUTY_A_HI && !sfr_wr
    |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("high byte readback");
  AST_LOW_HIDDEN: assert property (
    md inside {3'h1, 3'h3, 3'h4, 3'h6} && sfr_wr && sfr_addr == `DOPM_ADDR_DUTY_A_LO ##1
    sfr_addr == `DOPM_ADDR_DUTY_A_LO && !sfr_wr |=> $stable(sfr_rdata)) else $error("low shown");

  // Main scenarios reached
  CVR_SINGLE: cover property (md == 3'h1 && $rose(output_pin_a));
  CVR_DENSITY: cover property (md == 3'h4 && $rose(output_pin_b));
  CVR_HOLD: cover property (md == 3'h7 && quiet);
endmodule

bind dopm_top dopm_top_sva CHK (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
  .output_pin_a, .output_pin_b, .pin_a_oe_n, .pin_b_oe_n);

//--- sim/dopm_load.sv
`timescale 1ns/10ps
// Far side: clock sources for the counter and a load that integrates the pins
module dopm_load (
  input  wire logic        ref_clk,
  input  wire logic        pin_a,
  input  wire logic        pin_b,
  output logic             crystal_clk,
  output logic             pll_clk,
  output logic             ext_clk,
  output logic      [31:0] high_a,
  output logic      [31:0] high_b
);
  // sources, edges kept 5 ns off the reference rising edges
  initial begin
    crystal_clk = 1'b0;
    pll_clk     = 1'b0;
    ext_clk     = 1'b0;
    high_a      = 32'h0;
    high_b      = 32'h0;
  end
  always #30 crystal_clk = ~crystal_clk;
  always #20 pll_clk = ~pll_clk;
  always #40 ext_clk = ~ext_clk;

  // Load sees the pin level mid-cycle, where it has settled
  always @(negedge ref_clk) begin
    high_a <= high_a + {31'h0, pin_a};
    high_b <= high_b + {31'h0, pin_b};
  end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/10ps
`include "dopm_defines.svh"
// Random duties over every clock choice, plus buffering and density corners
module tb_top;
  logic        ref_clk, rst, sfr_wr, xtal, pll, ext, pa, pb, oea, oeb;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic [31:0] ha, hb, cyc, t0, t1, len, duty;
  int          mismatches = 0;
  int          comparisons = 0;

  dopm_top DUT (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
    .crystal_clk_in(xtal), .pll_clk_in(pll), .external_clock_pin(ext), .output_pin_a(pa),
    .output_pin_b(pb), .pin_a_oe_n(oea), .pin_b_oe_n(oeb));
  dopm_load LOAD (.ref_clk, .pin_a(pa), .pin_b(pb), .crystal_clk(xtal), .pll_clk(pll),
    .ext_clk(ext), .high_a(ha), .high_b(hb));

  // Clock and cycle count
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  initial cyc = 32'h0;
  always @(posedge ref_clk) cyc <= cyc + 32'h1;

  // Reference cycles per counter tick: sources 0..3 then prescaler
  function automatic logic [31:0] tick_len(input logic [1:0] s, input logic [1:0] p);
    logic [31:0] u;
    u = (s == 2'h0) ? 32'h5A : (s == 2'h1) ? 32'h6 : (s == 2'h2) ? 32'h8 : 32'h4;
    return u << (2 * p);
  endfunction
  // High cycles in 1024 with a tick every 4; return-to-zero keeps half
  function automatic logic [31:0] dens(input logic [15:0] v, input logic rz);
    return {16'h0, v} >> (6 + rz);
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // One write strobe, then an idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    sfr_addr = a;
    @(negedge ref_clk);
    chk("rdata", {24'h0, e}, {24'h0, sfr_rdata});
  endtask
  // Bounded wait for a level on pin a
  task automatic wait_a(input logic v);
    int n;
    n = 0;
    while (pa !== v && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20000) chk("pin wait", 32'h0, 32'h1);
  endtask
  // Bounded wait for a level on pin b
  task automatic wait_b(input logic v);
    int n;
    n = 0;
    while (pb !== v && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20000) chk("pin b wait", 32'h0, 32'h1);
  endtask
  task automatic run_len(output logic [31:0] l);
    wait_a(1'b0);
    wait_a(1'b1);
    t1 = cyc;
    wait_a(1'b0);
    l = cyc - t1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog at about three times the expected run
  initial begin
    #500000;
    chk("watchdog", 32'h0, 32'h1);
    report_and_stop;
  end

  initial begin
    void'($urandom(32'hA9B6));
    rst = 1'b1;
    sfr_wr = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    rd_chk(`DOPM_ADDR_CTRL, 8'h00);
    rd_chk(8'hB0, 8'h00);
    wr(`DOPM_ADDR_CTRL, 8'hFF);
    rd_chk(`DOPM_ADDR_CTRL, 8'h7F);
    // Every mode: which pins the modulator claims
    for (int m = 0; m < 8; m++) begin
      wr(`DOPM_ADDR_CTRL, {1'b0, m[2:0], 4'h3});
      repeat (8) @(negedge ref_clk);
      chk("oe", {30'h0, m == 0 || m == 7, m < 2 || m == 7}, {30'h0, oea, oeb});
    end
    // Mode 1 over all four sources, each with the prescaler of the same number, random duty, period 16
    for (int s = 0; s < 4; s++) begin
      duty = 32'h1 + ($urandom % 32'hF);
      wr(`DOPM_ADDR_CTRL, 8'h00);
      wr(`DOPM_ADDR_DUTY_A_LO, duty[7:0]);
      wr(`DOPM_ADDR_DUTY_A_HI, 8'h00);
      wr(`DOPM_ADDR_DUTY_B_LO, 8'h10);
      wr(`DOPM_ADDR_DUTY_B_HI, 8'h00);
      wr(`DOPM_ADDR_CTRL, {4'h1, s[1:0], s[1:0]});
      t0 = cyc;
      wait_a(1'b1);
      chk("restart", 32'h1, {31'h0, cyc - t0 < 32'h5});
      run_len(len);
      chk("high run", duty * tick_len(s[1:0], s[1:0]), len);
    end
    // New duty written mid-pulse takes effect only next period
    wr(`DOPM_ADDR_CTRL, 8'h00);
    wr(`DOPM_ADDR_DUTY_A_LO, 8'h05);
    wr(`DOPM_ADDR_DUTY_A_HI, 8'h00);
    wr(`DOPM_ADDR_CTRL, 8'h13);
    // Skip the first period, whose first tick falls at an arbitrary phase
    wait_a(1'b1);
    wait_a(1'b0);
    wait_a(1'b1);
    t0 = cyc;
    wr(`DOPM_ADDR_DUTY_A_LO, 8'h09);
    rd_chk(`DOPM_ADDR_DUTY_A_LO, 8'h05);
    wr(`DOPM_ADDR_DUTY_A_HI, 8'h00);
    wait_a(1'b0);
    chk("old run", 32'h14, cyc - t0);
    run_len(len);
    chk("new run", 32'h24, len);
    rd_chk(`DOPM_ADDR_DUTY_A_LO, 8'h09);
    // Mode 3: both pins start together, each falls at its own duty
    wr(`DOPM_ADDR_CTRL, 8'h00);
    wr(`DOPM_ADDR_DUTY_A_LO, 8'h03);
    wr(`DOPM_ADDR_DUTY_A_HI, 8'h00);
    wr(`DOPM_ADDR_DUTY_B_LO, 8'h08);
    wr(`DOPM_ADDR_DUTY_B_HI, 8'h00);
    wr(`DOPM_ADDR_CTRL, 8'h33);
    wait_a(1'b1);
    chk("twin16 start", 32'h1, {31'h0, pb});
    wait_a(1'b0);
    t0 = cyc;
    wait_b(1'b0);
    chk("twin16 gap", 32'h5 * tick_len(2'h3, 2'h0), cyc - t0);
    // Mode 2: shared 8-bit period, pin b high inside a byte window
    wr(`DOPM_ADDR_CTRL, 8'h00);
    wr(`DOPM_ADDR_DUTY_A_LO, 8'h05);
    wr(`DOPM_ADDR_DUTY_A_HI, 8'h0C);
    wr(`DOPM_ADDR_DUTY_B_LO, 8'h0F);
    wr(`DOPM_ADDR_DUTY_B_HI, 8'h04);
    wr(`DOPM_ADDR_CTRL, 8'h23);
    wait_b(1'b1);
    t0 = cyc;
    wait_b(1'b0);
    chk("twin8 window", 32'h8 * tick_len(2'h3, 2'h0), cyc - t0);
    run_len(len);
    chk("twin8 a", 32'h5 * tick_len(2'h3, 2'h0), len);
    wait_a(1'b1);
    chk("twin8 period", 32'h10 * tick_len(2'h3, 2'h0), cyc - t1);
    // Mode 5: each pin on its own byte counter
    wr(`DOPM_ADDR_CTRL, 8'h00);
    wr(`DOPM_ADDR_DUTY_A_LO, 8'h03);
    wr(`DOPM_ADDR_DUTY_A_HI, 8'h02);
    wr(`DOPM_ADDR_DUTY_B_LO, 8'h0B);
    wr(`DOPM_ADDR_DUTY_B_HI, 8'h07);
    wr(`DOPM_ADDR_CTRL, 8'h53);
    wait_a(1'b1);
    run_len(len);
    chk("dual8 a", 32'h3 * tick_len(2'h3, 2'h0), len);
    wait_a(1'b1);
    chk("dual8 a period", 32'hC * tick_len(2'h3, 2'h0), cyc - t1);
    wait_b(1'b0);
    wait_b(1'b1);
    t0 = cyc;
    wait_b(1'b0);
    chk("dual8 b", 32'h2 * tick_len(2'h3, 2'h0), cyc - t0);
    wait_b(1'b1);
    chk("dual8 b period", 32'h8 * tick_len(2'h3, 2'h0), cyc - t0);
    // Density modes, NRZ then RZ
    wr(`DOPM_ADDR_CTRL, 8'h00);
    wr(`DOPM_ADDR_DUTY_A_LO, 8'h00);
    wr(`DOPM_ADDR_DUTY_A_HI, 8'h40);
    wr(`DOPM_ADDR_DUTY_B_LO, 8'h00);
    wr(`DOPM_ADDR_DUTY_B_HI, 8'h80);
    for (int r = 0; r < 2; r++) begin
      wr(`DOPM_ADDR_CTRL, r ? 8'h63 : 8'h43);
      repeat (64) @(negedge ref_clk);
      t0 = ha;
      t1 = hb;
      repeat (1024) @(negedge ref_clk);
      chk("density a", dens(16'h4000, r[0]), ha - t0);
      chk("density b", dens(16'h8000, r[0]), hb - t1);
    end
    // Reset again mid-run
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    rd_chk(`DOPM_ADDR_CTRL, 8'h00);
    report_and_stop;
  end
endmodule
